// ===== rtl/gdsr_pkg.sv
// types and constants for the gauge driver device status report
`default_nettype none
package gdsr_pkg;

  localparam int unsigned WORD_W    = 16;
  // command word: address field on top, view select, gauge enables
  localparam int unsigned ADDR_LSB  = 13;
  localparam int unsigned ADDR_MSB  = 15;
  localparam logic [2:0]  CMD_ADDR  = 3'h1;
  localparam int unsigned SEL_LSB   = 8;
  localparam int unsigned SEL_MSB   = 11;
  localparam int unsigned EN_G0     = 0;
  localparam int unsigned EN_G1     = 1;
  localparam int unsigned SEL_ALT   = 3;
  localparam logic [3:0]  SEL_RESET = 4'h0;
  localparam logic [1:0]  EN_RESET  = 2'h0;
  localparam logic [3:0]  CNT_FIRST = 4'h1;

  // device status word, msb first; index 1 is gauge 1
  typedef struct packed {
    logic [1:0] heading;
    logic [1:0] zero_side;
    logic [1:0] off_target;
    logic       supply_high_flag;
    logic       supply_low_flag;
    logic       clock_cal_bad;
    logic       supply_fault_any;
    logic [1:0] position_changed;
    logic [1:0] homing_active;
    logic [1:0] thermal_flag;
  } gdsr_status_t;

  // events and levels from the motion and supervisor logic
  typedef struct packed {
    logic [1:0] heading;
    logic [1:0] zero_side;
    logic [1:0] off_target;
    logic [1:0] pos_step;
    logic [1:0] homing_on;
    logic [1:0] zero_found;
    logic [1:0] homing_off;
    logic [1:0] thermal_evt;
    logic       supply_high_evt;
    logic       supply_low_evt;
    logic       clock_cal_bad;
  } gdsr_evt_t;

  // what the link leaves behind after a frame
  typedef struct packed {
    logic              len_ok;
    logic              tag;
    logic [WORD_W-1:0] data;
  } gdsr_rx_t;

endpackage
`default_nettype wire

// ===== rtl/gdsr_spi_link.sv
// serial shifter on the link clock
`default_nettype none
module gdsr_spi_link (
  input  wire logic                  sclk,
  input  wire logic                  nrst,
  input  wire logic                  cs_n,
  input  wire logic                  si,
  input  wire logic                  tag,
  input  wire logic [15:0]           snap,
  output var  logic                  so_out,
  output var  logic                  so_oe,
  output var  gdsr_pkg::gdsr_rx_t    rx
);
  import gdsr_pkg::*;

  logic        run_q;
  logic [3:0]  cnt_q, cnt_d;
  logic [15:0] tx_q, tx_d;
  gdsr_rx_t    rx_q, rx_d;

  // cleared by the frame's own select, so no edge is needed after it
  always_ff @(posedge sclk or posedge cs_n) begin
    if (cs_n) begin
      run_q <= 1'b0;
    end else begin
      run_q <= 1'b1;
    end
  end

  always_comb begin
    cnt_d       = run_q ? cnt_q + 4'h1 : CNT_FIRST;
    // first edge loads the snapshot, later edges shift it up, with si filling the bottom bit
    tx_d        = run_q ? {tx_q[14:0], si} : {snap[14:0], si};
    rx_d.data   = {rx_q.data[14:0], si};
    rx_d.len_ok = (cnt_d == 4'h0);
    rx_d.tag    = tag;
  end

  always_ff @(posedge sclk or negedge nrst) begin
    if (!nrst) begin
      cnt_q <= 4'h0;
      tx_q  <= 16'h0000;
      rx_q  <= '0;
    end else begin
      cnt_q <= cnt_d;
      tx_q  <= tx_d;
      rx_q  <= rx_d;
    end
  end

  assign so_out = run_q ? tx_q[15] : snap[15];
  assign so_oe  = ~cs_n;
  assign rx     = rx_q;
endmodule
`default_nettype wire

// ===== rtl/gdsr_status.sv
// device status word builder, fault latches and command decode
`default_nettype none
// How it works
// - chosen status view holds until another select write or reset
// - top select bit zero picks the device status word
// - bits 15 and 14 give gauge 1 and gauge 0 heading
// - bits 13 and 12 give each gauge's configured zero side
// - bits 11 and 10 are one while a pointer is off target
// - bit 9 latches any supply overvoltage since the last device status read
// - overvoltage switches off both gauges' coil drivers
// - bit 8 latches undervoltage, which never disables outputs
// - bit 7 shows clock calibration outside tolerance
// - bit 6 is the OR of both supply flags
// - bits 5 and 4 latch pointer movement since the last device status read
// - bits 3 and 2 show homing until the message after zero
// - bits 1 and 0 latch overtemperature and disable that gauge
// - overtemperature flag clears only when that gauge is re-enabled
// - shifted-in data alters no status bit except bits 1 and 0, which an enable write clears
// - select falling loads the chosen word, sent msb first
// - fault latches clear only after a valid-length status read
// - valid length is nonzero and a multiple of sixteen bits
module gdsr_status (
  input  wire logic                clk_sys,
  input  wire logic                nrst,
  input  wire logic                sclk,
  input  wire logic                cs_n,
  input  wire logic                si,
  input  wire gdsr_pkg::gdsr_evt_t ev,
  input  wire logic [15:0]         alt_status_word,
  output var  logic                so_out,
  output var  logic                so_oe,
  output var  logic [1:0]          coil_enable,
  output var  logic [3:0]          status_view_select
);
  import gdsr_pkg::*;

  // ****************************************
  // link side and select synchroniser
  // ****************************************
  logic         cs_f;
  gdsr_rx_t     rx;
  logic         tag_q, tag_d;
  logic [15:0]  snap_q, snap_d;
  logic         snap_dev_q, snap_dev_d;
  logic         cs_old_q;

  gdsr_sync3 #(
    .RST (1'b1)
  ) u_cs_sync (
    .clk_sys (clk_sys),
    .nrst    (nrst),
    .d       (cs_n),
    .q       (cs_f)
  );

  // snapshot and tag are held still for the whole frame
  gdsr_spi_link u_link (
    .sclk   (sclk),
    .nrst   (nrst),
    .cs_n   (cs_n),
    .si     (si),
    .tag    (tag_q),
    .snap   (snap_q),
    .so_out (so_out),
    .so_oe  (so_oe),
    .rx     (rx)
  );

  // ****************************************
  // frame events
  // ****************************************
  logic cs_fall;
  logic cs_rise;
  logic frame_ok;
  logic cmd_hit;
  logic clr;

  assign cs_fall  = cs_old_q & ~cs_f;
  assign cs_rise  = ~cs_old_q & cs_f;
  // a frame with no clock edge leaves a stale tag behind
  assign frame_ok = cs_rise & rx.len_ok & (rx.tag == tag_q);
  assign cmd_hit  = frame_ok &
                    (rx.data[ADDR_MSB:ADDR_LSB] == CMD_ADDR);
  // latched faults go only when the device word was sent in full
  assign clr      = frame_ok & snap_dev_q;

  // ****************************************
  // state
  // ****************************************
  logic [3:0]   sel_q, sel_d;
  logic [1:0]   gauge_en_q, gauge_en_d;
  logic         ov_q, ov_d;
  logic         uv_q, uv_d;
  logic [1:0]   mov_q, mov_d;
  logic [1:0]   hold_q, hold_d;
  logic [1:0]   ot_q, ot_d;
  gdsr_status_t status_now;
  gdsr_status_t snap_s;

  assign snap_s = gdsr_status_t'(snap_q);

  always_comb begin
    status_now.heading          = ev.heading;
    status_now.zero_side        = ev.zero_side;
    status_now.off_target       = ev.off_target;
    status_now.supply_high_flag = ov_q;
    status_now.supply_low_flag  = uv_q;
    status_now.clock_cal_bad    = ev.clock_cal_bad;
    status_now.supply_fault_any = ov_q | uv_q;
    status_now.position_changed = mov_q;
    status_now.homing_active    = ev.homing_on | hold_q;
    status_now.thermal_flag     = ot_q;
  end

  always_comb begin
    tag_d      = tag_q;
    snap_d     = snap_q;
    snap_dev_d = snap_dev_q;
    if (cs_fall) begin
      tag_d      = ~tag_q;
      snap_dev_d = ~sel_q[SEL_ALT];
      snap_d     = sel_q[SEL_ALT] ? alt_status_word
                                  : 16'(status_now);
    end
  end

  always_comb begin
    // only a valid command write moves the view
    sel_d = cmd_hit ? rx.data[SEL_MSB:SEL_LSB] : sel_q;

    gauge_en_d = gauge_en_q;
    if (cmd_hit) begin
      gauge_en_d = {rx.data[EN_G1], rx.data[EN_G0]};
    end
    // shutdown events override a same-cycle enable write
    if (ev.supply_high_evt) begin
      gauge_en_d = 2'h0;
    end
    gauge_en_d = gauge_en_d & ~ev.thermal_evt;

    // set wins over clear; clear uses the snapshot bit only
    ov_d  = (ov_q & ~(clr & snap_s.supply_high_flag))
          | ev.supply_high_evt;
    uv_d  = (uv_q & ~(clr & snap_s.supply_low_flag))
          | ev.supply_low_evt;
    mov_d = (mov_q & ~({2{clr}} & snap_s.position_changed))
          | ev.pos_step;

    // zero found keeps the flag up until the next message
    hold_d = (hold_q & ~({2{clr}} & snap_s.homing_active)
                     & ~ev.homing_off)
           | (ev.zero_found & ~ev.homing_off);

    // read alone never clears, only an enable write does
    ot_d = ot_q;
    if (cmd_hit) begin
      ot_d = ot_q & ~{rx.data[EN_G1], rx.data[EN_G0]};
    end
    ot_d = ot_d | ev.thermal_evt;
    // shifted-in bits reach no status latch other than via commands
  end

  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      cs_old_q   <= 1'b1;
      tag_q      <= 1'b0;
      snap_q     <= 16'h0000;
      snap_dev_q <= 1'b1;
      sel_q      <= SEL_RESET;
      gauge_en_q <= EN_RESET;
      ov_q       <= 1'b0;
      uv_q       <= 1'b0;
      mov_q      <= 2'h0;
      hold_q     <= 2'h0;
      ot_q       <= 2'h0;
    end else begin
      cs_old_q   <= cs_f;
      tag_q      <= tag_d;
      snap_q     <= snap_d;
      snap_dev_q <= snap_dev_d;
      sel_q      <= sel_d;
      gauge_en_q <= gauge_en_d;
      ov_q       <= ov_d;
      uv_q       <= uv_d;
      mov_q      <= mov_d;
      hold_q     <= hold_d;
      ot_q       <= ot_d;
    end
  end

  assign coil_enable        = gauge_en_q;
  assign status_view_select = sel_q;

  // ****************************************
  // checks
  // ****************************************
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!nrst);

  a_view_held: assert property (
    !cs_rise |=> $stable(sel_q)
  ) else $error("status view changed without a frame");

  a_dev_pick: assert property (
    cs_fall && !sel_q[SEL_ALT]
      |=> snap_q == 16'($past(status_now)) && snap_dev_q
  ) else $error("device word not loaded at select fall");

  a_ov_shutdown: assert property (
    ev.supply_high_evt |=> coil_enable == 2'h0
  ) else $error("overvoltage left a gauge enabled");

  a_ov_latched: assert property (
    ev.supply_high_evt |=> ov_q ##0 status_now.supply_fault_any
  ) else $error("overvoltage event lost");

  a_uv_no_off: assert property (
    ev.supply_low_evt && !ev.supply_high_evt
      && ev.thermal_evt == 2'h0 && !cmd_hit
      |=> $stable(gauge_en_q) ##0 uv_q
  ) else $error("undervoltage changed enables");

  a_fault_or: assert property (
    (ov_q || uv_q) && !clr |=> status_now.supply_fault_any
  ) else $error("supply fault summary dropped");

  a_ot_sticky: assert property (
    ot_q[0] && !(cmd_hit && rx.data[EN_G0]) |=> ot_q[0]
  ) else $error("thermal flag cleared without enable");

  a_bad_len_keep: assert property (
    cs_rise && !frame_ok && ov_q |=> ov_q [*2]
  ) else $error("invalid frame cleared a fault");

  a_late_event: assert property (
    clr && ev.pos_step[1] |=> mov_q[1]
  ) else $error("movement during clear was lost");

  a_zero_hold: assert property (
    ev.zero_found[0] && !ev.homing_off[0]
      |=> status_now.homing_active[0]
  ) else $error("homing flag dropped at zero detect");

  a_ot_disable: assert property (
    ev.thermal_evt[1] |=> !coil_enable[1] && ot_q[1]
  ) else $error("hot gauge not disabled");

  a_hot0_off: assert property (
    ev.thermal_evt[0] |=> !coil_enable[0] && ot_q[0]
  ) else $error("hot gauge 0 not disabled");

  a_uv_latched: assert property (
    ev.supply_low_evt |=> uv_q && status_now.supply_fault_any
  ) else $error("undervoltage event lost");

  a_mov_latched: assert property (
    ev.pos_step[0] |=> mov_q[0]
  ) else $error("gauge 0 movement not latched");

  a_mov_clear: assert property (
    clr && snap_s.position_changed[0] && !ev.pos_step[0] |=> !mov_q[0]
  ) else $error("reported movement not cleared");

  a_home_off: assert property (
    ev.homing_off[1] |=> !hold_q[1]
  ) else $error("homing hold survived homing off");

  a_cmd_view: assert property (
    cmd_hit |=> sel_q == $past(rx.data[SEL_MSB:SEL_LSB])
  ) else $error("command write did not set the view");

  a_alt_pick: assert property (
    cs_fall && sel_q[SEL_ALT]
      |=> snap_q == $past(alt_status_word) && !snap_dev_q
  ) else $error("other view not loaded at select fall");

  a_snap_still: assert property (
    !cs_fall |=> $stable(snap_q)
  ) else $error("snapshot moved inside a frame");

  // a fault with no clearing frame must survive any cycle
  a_ov_hold: assert property (
    ov_q && !clr |=> ov_q
  ) else $error("overvoltage flag dropped without a read");

  a_uv_hold: assert property (
    uv_q && !clr |=> uv_q
  ) else $error("undervoltage flag dropped without a read");

  a_ot_release: assert property (
    cmd_hit && rx.data[EN_G0] && !ev.thermal_evt[0] |=> !ot_q[0]
  ) else $error("enable write left thermal flag set");

  a_ot1_sticky: assert property (
    ot_q[1] && !(cmd_hit && rx.data[EN_G1]) |=> ot_q[1]
  ) else $error("gauge 1 thermal flag cleared without enable");

endmodule
`default_nettype wire

// ===== rtl/gdsr_sync3.sv
// three-stage pin synchroniser with agreement filter
`default_nettype none
module gdsr_sync3 #(
  parameter logic RST = 1'b1
) (
  input  wire logic clk_sys,
  input  wire logic nrst,
  input  wire logic d,
  output var  logic q
);
  logic s1_q, s2_q, s3_q, q_q;
  logic s1_d, s2_d, s3_d, q_d;

  always_comb begin
    s1_d = d;
    s2_d = s1_q;
    s3_d = s2_q;
    // a change counts only once stages two and three agree
    q_d  = (s2_q == s3_q) ? s3_q : q_q;
  end

  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      s1_q <= RST;
      s2_q <= RST;
      s3_q <= RST;
      q_q  <= RST;
    end else begin
      s1_q <= s1_d;
      s2_q <= s2_d;
      s3_q <= s3_d;
      q_q  <= q_d;
    end
  end

  assign q = q_q;
endmodule
`default_nettype wire

// ===== testbench/gdsr_spi_host.sv
// spi master model that reads status words and sends commands
`default_nettype none
module gdsr_spi_host (
  output var  logic sclk,
  output var  logic cs_n,
  output var  logic si,
  input  wire logic so_out
);
  timeunit 1ns;
  timeprecision 100ps;
  // ****************************************
  // frame engine, mode 0, 6 ns link clock
  // ****************************************
  initial begin
    sclk = 1'b0;
    cs_n = 1'b1;
    si   = 1'b1;
  end
  // clock stands low outside frames; so sampled just before each rise
  task automatic xfer(input logic [15:0] tx, input int n,
                      output logic [15:0] rx);
    rx = '0;
    cs_n = 1'b0;
    #80;
    for (int i = 0; i < n; i++) begin
      si = tx[15-i];
      #3;
      rx = {rx[14:0], so_out};
      sclk = 1'b1;
      #3;
      sclk = 1'b0;
    end
    // released line shows no stale value
    si = ~si;
    #3;
    cs_n = 1'b1;
    // gap covers the command decode after select rises
    #100;
  endtask
endmodule
`default_nettype wire

// ===== testbench/gdsr_status_tb.sv
// self-checking bench for the device status report
`default_nettype none
module gdsr_status_tb;
  timeunit 1ns;
  timeprecision 100ps;
  import gdsr_pkg::*;
  // ****************************************
  // harness
  // ****************************************
  localparam logic [15:0] NOP  = 16'h0000;
  localparam logic [15:0] ENA  = 16'h2003;
  localparam logic [15:0] BASE = 16'h9880;
  localparam logic [15:0] ALT  = 16'hA5C3;
  logic        clk_sys;
  logic        nrst;
  logic        sclk;
  logic        cs_n;
  logic        si;
  logic        so_out;
  logic        oe;
  logic [1:0]  coil;
  logic [3:0]  sel;
  logic [15:0] w;
  gdsr_evt_t   ev;
  int          miscompares = 0;
  int          check_count = 0;

  gdsr_status dut (.clk_sys(clk_sys), .nrst(nrst), .sclk(sclk),
    .cs_n(cs_n), .si(si), .ev(ev), .alt_status_word(ALT),
    .so_out(so_out), .so_oe(oe), .coil_enable(coil),
    .status_view_select(sel));
  gdsr_spi_host host (.sclk(sclk), .cs_n(cs_n), .si(si),
    .so_out(so_out));

  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end

  task automatic tick();
    @(posedge clk_sys);
    #1;
  endtask
  task automatic chk(input string nm, input logic [15:0] e, g);
    check_count++;
    if (g !== e) begin
      $display("[ERR] %s expected %h seen %h", nm, e, g);
      miscompares++;
    end
  endtask
  task automatic rdc(input logic [15:0] c, e);
    host.xfer(c, 16, w);
    // back on the clock grid before any event is driven
    tick();
    chk("word", e, w);
  endtask
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  // ****************************************
  // scenarios
  // ****************************************
  task automatic t_reset();
    chk("coil", 16'h0000, {14'h0, coil});
    chk("sel", 16'h0000, {12'h0, sel});
    fork
      rdc(NOP, BASE);
      begin
        #40;
        chk("oe", 16'h0001, {15'h0, oe});
      end
    join
    chk("oe", 16'h0000, {15'h0, oe});
    $display("t_reset done");
  endtask
  task automatic t_supply();
    rdc(ENA, BASE);
    chk("coil", 16'h0003, {14'h0, coil});
    ev.supply_low_evt = 1'b1;
    tick();
    ev.supply_low_evt = 1'b0;
    chk("coil", 16'h0003, {14'h0, coil});
    rdc(NOP, BASE | 16'h0140);
    rdc(NOP, BASE);
    ev.supply_high_evt = 1'b1;
    tick();
    ev.supply_high_evt = 1'b0;
    chk("coil", 16'h0000, {14'h0, coil});
    rdc(NOP, BASE | 16'h0240);
    rdc(ENA, BASE);
    chk("coil", 16'h0003, {14'h0, coil});
    $display("t_supply done");
  endtask
  task automatic t_short();
    ev.pos_step[0] = 1'b1;
    ev.supply_high_evt = 1'b1;
    tick();
    ev.pos_step[0] = 1'b0;
    ev.supply_high_evt = 1'b0;
    host.xfer(16'h2803, 8, w);
    chk("sel", 16'h0000, {12'h0, sel});
    rdc(NOP, BASE | 16'h0250);
    ev.pos_step[1] = 1'b1;
    tick();
    rdc(ENA, BASE | 16'h0020);
    ev.pos_step[1] = 1'b0;
    rdc(NOP, BASE | 16'h0020);
    rdc(NOP, BASE);
    chk("coil", 16'h0003, {14'h0, coil});
    $display("t_short done");
  endtask
  task automatic t_therm();
    ev.thermal_evt[0] = 1'b1;
    tick();
    ev.thermal_evt[0] = 1'b0;
    chk("coil", 16'h0002, {14'h0, coil});
    rdc(NOP, BASE | 16'h0001);
    rdc(NOP, BASE | 16'h0001);
    rdc(ENA, BASE | 16'h0001);
    chk("coil", 16'h0003, {14'h0, coil});
    rdc(NOP, BASE);
    ev.thermal_evt[1] = 1'b1;
    tick();
    ev.thermal_evt[1] = 1'b0;
    chk("coil", 16'h0001, {14'h0, coil});
    rdc(ENA, BASE | 16'h0002);
    chk("coil", 16'h0003, {14'h0, coil});
    rdc(NOP, BASE);
    $display("t_therm done");
  endtask
  task automatic t_home();
    ev.homing_on[0] = 1'b1;
    tick();
    rdc(NOP, BASE | 16'h0004);
    ev.homing_on[0] = 1'b0;
    ev.zero_found[0] = 1'b1;
    tick();
    ev.zero_found[0] = 1'b0;
    rdc(NOP, BASE | 16'h0004);
    rdc(NOP, BASE);
    ev.homing_on[1] = 1'b1;
    tick();
    ev.homing_on[1] = 1'b0;
    ev.homing_off[1] = 1'b1;
    tick();
    ev.homing_off[1] = 1'b0;
    rdc(NOP, BASE);
    $display("t_home done");
  endtask
  task automatic t_select();
    rdc(16'h2803, BASE);
    chk("sel", 16'h0008, {12'h0, sel});
    rdc(NOP, ALT);
    rdc(NOP, ALT);
    rdc(16'h2703, ALT);
    chk("sel", 16'h0007, {12'h0, sel});
    rdc(16'hFFFF, BASE);
    rdc(NOP, BASE);
    $display("t_select done");
  endtask

  initial begin
    nrst = 1'b0;
    ev = '0;
    ev.heading = 2'b10;
    ev.zero_side = 2'b01;
    ev.off_target = 2'b10;
    ev.clock_cal_bad = 1'b1;
    repeat (6) tick();
    nrst = 1'b1;
    repeat (6) tick();
    t_reset();
    t_supply();
    t_short();
    t_therm();
    t_home();
    t_select();
    report_and_stop();
  end

  // whole run is about 8 us of frames
  initial begin
    #50000;
    miscompares++;
    report_and_stop();
  end
endmodule
`default_nettype wire
